/* File: verilog/ccs_pkg.sv */
/*
  Constants for the CPU clock switch control block: register offsets,
  field positions, reset values and switchover counts.
  Assumes an 8-bit register port with byte offsets.
*/
package ccs_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] PROC_CLK_CTRL_OFS = 8'h00;
  localparam logic [7:0] MAIN_CLK_MODE_OFS = 8'h01;
  localparam logic [7:0] OSC_MODE_SEL_OFS = 8'h02;
  localparam logic [7:0] MAIN_OSC_CTRL_OFS = 8'h03;
  localparam logic [7:0] INT_OSC_MODE_OFS = 8'h04;
  localparam logic [7:0] PORT_FUNC_CTRL_OFS = 8'h05;
  localparam logic [7:0] OSC_STATUS_OFS = 8'h06;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 2;
  localparam int CSS_BIT = 4;
  localparam int CLS_BIT = 5;
  localparam int MSEL_BIT = 0;
  localparam int MCS_BIT = 1;
  localparam int HIGH_SPEED_PATH_UNLOCK_BIT = 2;
  localparam int EXT_MAIN_BIT = 7;
  localparam int PIN_OSC_BIT = 6;
  localparam int EXT_SUB_BIT = 5;
  localparam int SUB_EN_BIT = 4;
  localparam int MHALT_BIT = 7;
  localparam int FHALT_BIT = 0;
  localparam int FRUN_BIT = 7;
  localparam int SUB_PIN_BIT = 1;
  localparam int SUB_OE_BIT = 0;
  localparam int SUB_STABLE_BIT = 0;

  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [2:0] DIV_MAX = 3'h4;
  localparam logic MHALT_RST = 1'b1;
  localparam logic [4:0] DIV_SW_BASE = 5'h10;
  localparam logic [4:0] SUB_TO_MAIN_CLKS = 5'h02;
  localparam logic [1:0] MAIN_TO_SUB_SUB_TICKS = 2'h2;
  localparam logic [1:0] SRC_SW_OLD_TICKS = 2'h1;
  localparam logic [1:0] SRC_SW_NEW_TICKS = 2'h2;

  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_COUNT = 2'b01,
    CCS_SUBW = 2'b11
  } ccs_state_type;

endpackage

/* File: verilog/ccs_sw_if.sv */
/*
  Carrier between the clock switch top and its main source switcher.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface ccs_sw_if;
  logic req;
  logic old_tick;
  logic new_tick;
  logic status;

  modport ctrl (output req, output old_tick, output new_tick, input status);
  modport sw (input req, input old_tick, input new_tick, output status);
endinterface

/* File: verilog/ccs_main_switch.sv */
/*
  Main system clock source switcher: internal fast oscillator versus
  high-speed system clock, with a switchover delay counted in ticks.
  Assumes source ticks are one-cycle pulses synchronous to clk_i.
*/
`timescale 1ns/10ps
module ccs_main_switch (
  input wire logic clk_i,
  input wire logic rst_n_i,
  ccs_sw_if.sw sw
);

  logic status_ff;
  logic [1:0] old_cnt_ff;
  logic [1:0] new_cnt_ff;

  assign sw.status = status_ff;

  // ************************************************************
  // Switchover: one old tick, then two new ticks
  // ************************************************************
  // Handover lands on a new tick edge, so neither source gives a short phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_ff <= 1'b0;
      old_cnt_ff <= 2'h0;
      new_cnt_ff <= 2'h0;
    end else if (sw.req == status_ff) begin
      old_cnt_ff <= 2'h0;
      new_cnt_ff <= 2'h0;
    end else if (old_cnt_ff != ccs_pkg::SRC_SW_OLD_TICKS) begin
      if (sw.old_tick) begin
        old_cnt_ff <= old_cnt_ff + 2'h1;
      end
    end else if (sw.new_tick) begin
      if (new_cnt_ff + 2'h1 == ccs_pkg::SRC_SW_NEW_TICKS) begin
        status_ff <= sw.req;
        old_cnt_ff <= 2'h0;
        new_cnt_ff <= 2'h0;
      end else begin
        new_cnt_ff <= new_cnt_ff + 2'h1;
      end
    end
  end

endmodule

/* File: verilog/ccs_cpu_clock_switch.sv */
/*
  CPU clock switch control: main source choice, main/subsystem choice,
  main divider, delayed switchover and gated oscillator stop requests.
  Assumes oscillator activity arrives as one-cycle tick pulses on clk_i
  and that software uses the 8-bit register port.
*/
`timescale 1ns/10ps
module ccs_cpu_clock_switch #(
  parameter logic [2:0] DIV_LIMIT = 3'h4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic fih_tick_i,
  input wire logic fxh_tick_i,
  input wire logic fsub_tick_i,
  input wire logic internal_fast_osc_running_i,
  input wire logic sub_osc_stable_flag_i,
  output logic cpu_tick_o,
  output logic cpu_source_status_o,
  output logic main_source_status_o,
  output logic internal_fast_osc_run_o,
  output logic main_osc_run_o,
  output logic main_external_input_select_o,
  output logic main_pin_osc_select_o,
  output logic sub_run_o,
  output logic sub_external_input_select_o,
  output logic sub_ext_input_pin_select_o,
  output logic sub_pin_output_enable_o
);

  // Counters and the clamp only cover dividers up to the widest one
  if (DIV_LIMIT > ccs_pkg::DIV_MAX) begin : g_div_limit_check
    $error("DIV_LIMIT above the widest divider");
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [2:0] div_ff;
  logic cls_ff;
  logic [2:0] pend_div_ff;
  logic pend_css_ff;
  logic main_sel_ff;
  logic high_speed_path_unlock_ff;
  logic high_speed_path_unlock_lock_ff;
  logic [3:0] osc_mode_ff;
  logic main_halt_ff;
  logic fast_halt_ff;
  logic [1:0] port_func_ff;
  logic [7:0] rdata_ff;
  logic cpu_tick_ff;
  logic [3:0] div_cnt_ff;
  logic [4:0] sw_cnt_ff;
  logic [4:0] sw_target_ff;
  logic [1:0] sub_cnt_ff;
  ccs_pkg::ccs_state_type state_ff;

  logic main_source_status;
  logic main_tick;
  logic main_cpu_tick;
  logic cpu_tick;
  logic wr_pcc;
  logic [3:0] div_last;

  ccs_sw_if sw_bus ();

  // ************************************************************
  // Main source switch
  // ************************************************************
  assign sw_bus.req = main_sel_ff & high_speed_path_unlock_ff;
  assign sw_bus.old_tick = main_source_status ? fxh_tick_i : fih_tick_i;
  assign sw_bus.new_tick = main_source_status ? fih_tick_i : fxh_tick_i;
  assign main_source_status = sw_bus.status;

  ccs_main_switch u_main_switch (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sw(sw_bus)
  );

  // ************************************************************
  // Clock ticks
  // ************************************************************
  assign main_tick = main_source_status ? fxh_tick_i : fih_tick_i;
  assign div_last = 4'((5'h1 << div_ff) - 5'h1);
  assign main_cpu_tick = main_tick && (div_cnt_ff == div_last);
  assign cpu_tick = cls_ff ? fsub_tick_i : main_cpu_tick;

  // Counter holds its count on main ticks while a main source change is pending and the sequencer is idle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt_ff <= 4'h0;
    end else if (main_source_status != sw_bus.req && main_tick && state_ff == ccs_pkg::CCS_IDLE) begin
      div_cnt_ff <= div_cnt_ff;
    end else if (main_cpu_tick) begin
      div_cnt_ff <= 4'h0;
    end else if (main_tick) begin
      div_cnt_ff <= div_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_tick_ff <= 1'b0;
    end else begin
      cpu_tick_ff <= cpu_tick;
    end
  end

  // ************************************************************
  // CPU clock switchover sequencer
  // ************************************************************
  assign wr_pcc = reg_wr_i && reg_addr_i == ccs_pkg::PROC_CLK_CTRL_OFS;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_div_ff <= ccs_pkg::DIV_RST;
      pend_css_ff <= 1'b0;
    end else if (wr_pcc) begin
      pend_div_ff <= (reg_wdata_i[ccs_pkg::DIV_MSB:ccs_pkg::DIV_LSB] > DIV_LIMIT) ?
                     DIV_LIMIT : reg_wdata_i[ccs_pkg::DIV_MSB:ccs_pkg::DIV_LSB];
      pend_css_ff <= reg_wdata_i[ccs_pkg::CSS_BIT];
    end
  end

  // The old clock and divider keep running until the count is spent
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ccs_pkg::CCS_IDLE;
      div_ff <= ccs_pkg::DIV_RST;
      cls_ff <= 1'b0;
      sw_cnt_ff <= 5'h0;
      sw_target_ff <= 5'h0;
      sub_cnt_ff <= 2'h0;
    end else begin
      case (state_ff)
        ccs_pkg::CCS_IDLE: begin
          sw_cnt_ff <= 5'h0;
          sub_cnt_ff <= 2'h0;
          if (pend_css_ff != cls_ff) begin
            if (!cls_ff) begin
              state_ff <= ccs_pkg::CCS_SUBW;
            end else begin
              sw_target_ff <= ccs_pkg::SUB_TO_MAIN_CLKS;
              state_ff <= ccs_pkg::CCS_COUNT;
            end
          end else if (pend_div_ff != div_ff && !cls_ff) begin
            sw_target_ff <= ccs_pkg::DIV_SW_BASE >> div_ff;
            state_ff <= ccs_pkg::CCS_COUNT;
          end else if (pend_div_ff != div_ff) begin
            div_ff <= pend_div_ff;
          end
        end
        ccs_pkg::CCS_COUNT: begin
          if (cpu_tick) begin
            if (sw_cnt_ff + 5'h1 == sw_target_ff) begin
              div_ff <= pend_div_ff;
              cls_ff <= pend_css_ff;
              state_ff <= ccs_pkg::CCS_IDLE;
            end else begin
              sw_cnt_ff <= sw_cnt_ff + 5'h1;
            end
          end
        end
        ccs_pkg::CCS_SUBW: begin
          if (sub_cnt_ff != ccs_pkg::MAIN_TO_SUB_SUB_TICKS) begin
            if (fsub_tick_i) begin
              sub_cnt_ff <= sub_cnt_ff + 2'h1;
            end
          end else if (cpu_tick) begin
            cls_ff <= pend_css_ff;
            div_ff <= pend_div_ff;
            state_ff <= ccs_pkg::CCS_IDLE;
          end
        end
        default: begin
          state_ff <= ccs_pkg::CCS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Main clock mode and oscillator control registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_sel_ff <= 1'b0;
      high_speed_path_unlock_ff <= 1'b0;
      high_speed_path_unlock_lock_ff <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ccs_pkg::MAIN_CLK_MODE_OFS) begin
      if (!cls_ff) begin
        main_sel_ff <= reg_wdata_i[ccs_pkg::MSEL_BIT];
      end
      if (!high_speed_path_unlock_lock_ff) begin
        high_speed_path_unlock_ff <= reg_wdata_i[ccs_pkg::HIGH_SPEED_PATH_UNLOCK_BIT];
        high_speed_path_unlock_lock_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_mode_ff <= 4'h0;
    end else if (reg_wr_i && reg_addr_i == ccs_pkg::OSC_MODE_SEL_OFS) begin
      osc_mode_ff <= reg_wdata_i[ccs_pkg::EXT_MAIN_BIT:ccs_pkg::SUB_EN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_halt_ff <= ccs_pkg::MHALT_RST;
    end else if (reg_wr_i && reg_addr_i == ccs_pkg::MAIN_OSC_CTRL_OFS) begin
      main_halt_ff <= reg_wdata_i[ccs_pkg::MHALT_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fast_halt_ff <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ccs_pkg::INT_OSC_MODE_OFS) begin
      fast_halt_ff <= reg_wdata_i[ccs_pkg::FHALT_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_func_ff <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == ccs_pkg::PORT_FUNC_CTRL_OFS) begin
      port_func_ff <= reg_wdata_i[ccs_pkg::SUB_PIN_BIT:ccs_pkg::SUB_OE_BIT];
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_ff <= 8'h00;
      case (reg_addr_i)
        ccs_pkg::PROC_CLK_CTRL_OFS: begin
          rdata_ff[ccs_pkg::DIV_MSB:ccs_pkg::DIV_LSB] <= pend_div_ff;
          rdata_ff[ccs_pkg::CSS_BIT] <= pend_css_ff;
          rdata_ff[ccs_pkg::CLS_BIT] <= cls_ff;
        end
        ccs_pkg::MAIN_CLK_MODE_OFS: begin
          rdata_ff[ccs_pkg::MSEL_BIT] <= main_sel_ff;
          rdata_ff[ccs_pkg::MCS_BIT] <= main_source_status;
          rdata_ff[ccs_pkg::HIGH_SPEED_PATH_UNLOCK_BIT] <= high_speed_path_unlock_ff;
        end
        ccs_pkg::OSC_MODE_SEL_OFS: begin
          rdata_ff[ccs_pkg::EXT_MAIN_BIT:ccs_pkg::SUB_EN_BIT] <= osc_mode_ff;
        end
        ccs_pkg::MAIN_OSC_CTRL_OFS: begin
          rdata_ff[ccs_pkg::MHALT_BIT] <= main_halt_ff;
        end
        ccs_pkg::INT_OSC_MODE_OFS: begin
          rdata_ff[ccs_pkg::FHALT_BIT] <= fast_halt_ff;
          rdata_ff[ccs_pkg::FRUN_BIT] <= internal_fast_osc_running_i;
        end
        ccs_pkg::PORT_FUNC_CTRL_OFS: begin
          rdata_ff[ccs_pkg::SUB_PIN_BIT:ccs_pkg::SUB_OE_BIT] <= port_func_ff;
        end
        ccs_pkg::OSC_STATUS_OFS: begin
          rdata_ff[ccs_pkg::SUB_STABLE_BIT] <= sub_osc_stable_flag_i;
        end
        default: begin
          rdata_ff <= 8'h00;
        end
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ************************************************************
  // Outputs and stop gating
  // ************************************************************
  // A halt bit stays stored but only bites once its clock is out of use
  assign internal_fast_osc_run_o = !(fast_halt_ff && (main_source_status || cls_ff));
  assign main_osc_run_o = !(main_halt_ff && (!main_source_status || cls_ff));
  assign sub_run_o = osc_mode_ff[ccs_pkg::SUB_EN_BIT - 4] || cls_ff;
  assign main_external_input_select_o = osc_mode_ff[ccs_pkg::EXT_MAIN_BIT - 4];
  assign main_pin_osc_select_o = osc_mode_ff[ccs_pkg::PIN_OSC_BIT - 4];
  assign sub_external_input_select_o = osc_mode_ff[ccs_pkg::EXT_SUB_BIT - 4];
  assign sub_ext_input_pin_select_o = port_func_ff[ccs_pkg::SUB_PIN_BIT];
  assign sub_pin_output_enable_o = port_func_ff[ccs_pkg::SUB_OE_BIT];
  assign cpu_tick_o = cpu_tick_ff;
  assign cpu_source_status_o = cls_ff;
  assign main_source_status_o = main_source_status;
  assign reg_rdata_o = rdata_ff;

endmodule

/* File: dv/ccs_cpu_clock_switch_asserts.sv */
/*
  Port-level checker for the CPU clock switch control block.
  Assumes one clock domain and the top module's port names; bound below.
*/
`timescale 1ns/10ps
module ccs_cpu_clock_switch_asserts #(
  parameter logic [2:0] DIV_LIMIT = 3'h4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic fih_tick_i,
  input wire logic fxh_tick_i,
  input wire logic fsub_tick_i,
  input wire logic cpu_tick_o,
  input wire logic cpu_source_status_o,
  input wire logic main_source_status_o,
  input wire logic internal_fast_osc_run_o,
  input wire logic main_osc_run_o,
  input wire logic sub_run_o
);
  // ************************************************************
  // Requests
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_sub_req;
    reg_wr_i && reg_addr_i == ccs_pkg::PROC_CLK_CTRL_OFS && reg_wdata_i[4] && !cpu_source_status_o;
  endsequence
  sequence s_main_ret;
    reg_wr_i && reg_addr_i == ccs_pkg::PROC_CLK_CTRL_OFS && !reg_wdata_i[4] && cpu_source_status_o;
  endsequence
  sequence s_msel_req;
    reg_wr_i && reg_addr_i == ccs_pkg::MAIN_CLK_MODE_OFS && reg_wdata_i[0] && !main_source_status_o;
  endsequence

  // ************************************************************
  // Properties
  // ************************************************************
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_rd_cls;
    $past(reg_rd_i && reg_addr_i == ccs_pkg::PROC_CLK_CTRL_OFS)
      |-> reg_rdata_o[5] == $past(cpu_source_status_o);
  endproperty
  a_rd_cls: assert property (p_rd_cls) else $error("cpu status bit wrong");
  property p_fast_gate;
    !main_source_status_o && !cpu_source_status_o |-> internal_fast_osc_run_o;
  endproperty
  a_fast_gate: assert property (p_fast_gate) else $error("fast osc stopped in use");
  property p_main_gate;
    main_source_status_o && !cpu_source_status_o |-> main_osc_run_o;
  endproperty
  a_main_gate: assert property (p_main_gate) else $error("main osc stopped in use");
  property p_sub_forced;
    cpu_source_status_o |-> sub_run_o;
  endproperty
  a_sub_forced: assert property (p_sub_forced) else $error("sub source off in use");
  property p_tick_src;
    cpu_tick_o |-> $past(cpu_source_status_o ? fsub_tick_i :
      (main_source_status_o ? fxh_tick_i : fih_tick_i));
  endproperty
  a_tick_src: assert property (p_tick_src) else $error("cpu tick without source tick");
  property p_sub_delay;
    s_sub_req |=> !cpu_source_status_o [*2];
  endproperty
  a_sub_delay: assert property (p_sub_delay) else $error("sub switch too early");
  property p_ret_delay;
    s_main_ret |=> cpu_source_status_o [*2];
  endproperty
  a_ret_delay: assert property (p_ret_delay) else $error("main return too early");
  property p_msel_locked;
    cpu_source_status_o && $past(cpu_source_status_o) |-> $stable(main_source_status_o);
  endproperty
  a_msel_locked: assert property (p_msel_locked) else $error("main source moved on sub");
  property p_msel_delay;
    s_msel_req |=> !main_source_status_o [*3];
  endproperty
  a_msel_delay: assert property (p_msel_delay) else $error("main source switch early");
endmodule

bind ccs_cpu_clock_switch ccs_cpu_clock_switch_asserts #(.DIV_LIMIT(DIV_LIMIT)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .fih_tick_i(fih_tick_i), .fxh_tick_i(fxh_tick_i), .fsub_tick_i(fsub_tick_i),
  .cpu_tick_o(cpu_tick_o), .cpu_source_status_o(cpu_source_status_o),
  .main_source_status_o(main_source_status_o),
  .internal_fast_osc_run_o(internal_fast_osc_run_o), .main_osc_run_o(main_osc_run_o),
  .sub_run_o(sub_run_o)
);

/* File: dv/tb_top.sv */
/*
  Self-checking testbench for the CPU clock switch control block.
  Assumes ticks come from the bench: fast every cycle, high-speed every
  second cycle, subsystem every fourth cycle.
*/
`timescale 1ns/10ps
module tb_top;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, cpu_tick_o, cpu_source_status_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
  logic fih_tick_i, internal_fast_osc_running_i, sub_osc_stable_flag_i;
  logic fxh_tick_i = 1'b0;
  logic fsub_tick_i = 1'b0;
  logic main_source_status_o, internal_fast_osc_run_o, main_osc_run_o, sub_run_o;
  logic main_external_input_select_o, main_pin_osc_select_o, sub_external_input_select_o;
  logic sub_ext_input_pin_select_o, sub_pin_output_enable_o;
  logic [1:0] tick_cnt_ff = 2'h0;
  int fails, samples_checked;

  ccs_cpu_clock_switch #(.DIV_LIMIT(3'h4)) dut_u (.clk_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fih_tick_i, .fxh_tick_i,
    .fsub_tick_i, .internal_fast_osc_running_i, .sub_osc_stable_flag_i, .cpu_tick_o,
    .cpu_source_status_o, .main_source_status_o, .internal_fast_osc_run_o,
    .main_osc_run_o, .main_external_input_select_o, .main_pin_osc_select_o, .sub_run_o,
    .sub_external_input_select_o, .sub_ext_input_pin_select_o, .sub_pin_output_enable_o);

  // ************************************************************
  // Clock and source ticks
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tick_cnt_ff <= tick_cnt_ff + 2'h1;
    fxh_tick_i <= tick_cnt_ff[0];
    fsub_tick_i <= (tick_cnt_ff == 2'h3);
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    // Let the write settle so following checks see the updated outputs
    #1;
  endtask
  // Read data is taken in the one cycle where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic count_ticks(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (32) begin
      @(posedge clk_i);
      #1 if (cpu_tick_o === 1'b1) n++;
    end
    chk(n, exp);
  endtask
  // Bounded wait on a status output, then judged
  task automatic wait_stat(input logic main_source_status, input logic v);
    int i;
    i = 0;
    while (i < 100 && (main_source_status ? main_source_status_o : cpu_source_status_o) !== v) begin
      @(posedge clk_i);
      #1 i++;
    end
    chk({7'h0, main_source_status ? main_source_status_o : cpu_source_status_o}, {7'h0, v});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    rd(ccs_pkg::MAIN_OSC_CTRL_OFS, rv); chk(rv, 8'h80);
    rd(ccs_pkg::INT_OSC_MODE_OFS, rv); chk(rv, 8'h80);
    rd(ccs_pkg::MAIN_CLK_MODE_OFS, rv); chk(rv, 8'h00);
    rd(8'h07, rv); chk(rv, 8'h00);
    chk({5'h0, main_osc_run_o, internal_fast_osc_run_o, sub_run_o}, 8'h02);
  endtask
  task automatic t_divider;
    wr(ccs_pkg::PROC_CLK_CTRL_OFS, 8'h02);
    rd(ccs_pkg::PROC_CLK_CTRL_OFS, rv); chk(rv, 8'h02);
    repeat (40) @(posedge clk_i);
    count_ticks(8'h08);
    wr(ccs_pkg::PROC_CLK_CTRL_OFS, 8'h07);
    repeat (40) @(posedge clk_i);
    count_ticks(8'h02);
    wr(ccs_pkg::PROC_CLK_CTRL_OFS, 8'h00);
    repeat (40) @(posedge clk_i);
    count_ticks(8'h20);
  endtask
  task automatic t_main_src;
    wr(ccs_pkg::MAIN_CLK_MODE_OFS, 8'h04);
    wr(ccs_pkg::MAIN_CLK_MODE_OFS, 8'h00);
    rd(ccs_pkg::MAIN_CLK_MODE_OFS, rv); chk(rv, 8'h04);
    wr(ccs_pkg::INT_OSC_MODE_OFS, 8'h01);
    wr(ccs_pkg::OSC_MODE_SEL_OFS, 8'h40);
    rd(ccs_pkg::OSC_MODE_SEL_OFS, rv); chk(rv, 8'h40);
    wr(ccs_pkg::MAIN_OSC_CTRL_OFS, 8'h00);
    chk({6'h0, internal_fast_osc_run_o, main_osc_run_o}, 8'h03);
    wr(ccs_pkg::MAIN_CLK_MODE_OFS, 8'h05);
    wait_stat(1'b1, 1'b1);
    rd(ccs_pkg::MAIN_CLK_MODE_OFS, rv); chk(rv, 8'h07);
    chk({7'h0, internal_fast_osc_run_o}, 8'h00);
    count_ticks(8'h10);
    wr(ccs_pkg::MAIN_OSC_CTRL_OFS, 8'h80);
    chk({7'h0, main_osc_run_o}, 8'h01);
  endtask
  task automatic t_sub;
    wr(ccs_pkg::PORT_FUNC_CTRL_OFS, 8'h01);
    wr(ccs_pkg::OSC_MODE_SEL_OFS, 8'h70);
    rd(ccs_pkg::OSC_STATUS_OFS, rv); chk(rv, 8'h01);
    wr(ccs_pkg::PROC_CLK_CTRL_OFS, 8'h10);
    wait_stat(1'b0, 1'b1);
    rd(ccs_pkg::PROC_CLK_CTRL_OFS, rv); chk(rv, 8'h30);
    // Clearing the subsystem enable while running on it must not bite
    wr(ccs_pkg::OSC_MODE_SEL_OFS, 8'h40);
    chk({7'h0, sub_run_o}, 8'h01);
    chk({7'h0, main_osc_run_o}, 8'h00);
    count_ticks(8'h08);
    wr(ccs_pkg::MAIN_CLK_MODE_OFS, 8'h04);
    rd(ccs_pkg::MAIN_CLK_MODE_OFS, rv); chk(rv, 8'h07);
    wr(ccs_pkg::MAIN_OSC_CTRL_OFS, 8'h00);
    wr(ccs_pkg::PROC_CLK_CTRL_OFS, 8'h00);
    wait_stat(1'b0, 1'b0);
    chk({7'h0, sub_run_o}, 8'h00);
    wr(ccs_pkg::INT_OSC_MODE_OFS, 8'h00);
    wr(ccs_pkg::MAIN_CLK_MODE_OFS, 8'h04);
    wait_stat(1'b1, 1'b0);
    wr(ccs_pkg::MAIN_OSC_CTRL_OFS, 8'h80);
    chk({7'h0, main_osc_run_o}, 8'h00);
  endtask
  // Second reset: the unlock bit must take one write again
  task automatic t_rereset;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ccs_pkg::PROC_CLK_CTRL_OFS, rv); chk(rv, 8'h00);
    chk({6'h0, main_source_status_o, cpu_source_status_o}, 8'h00);
    wr(ccs_pkg::MAIN_CLK_MODE_OFS, 8'h04);
    rd(ccs_pkg::MAIN_CLK_MODE_OFS, rv); chk(rv, 8'h04);
    wr(ccs_pkg::OSC_MODE_SEL_OFS, 8'hf0);
    wr(ccs_pkg::PORT_FUNC_CTRL_OFS, 8'h03);
    rd(ccs_pkg::PORT_FUNC_CTRL_OFS, rv); chk(rv, 8'h03);
    chk({3'h0, main_external_input_select_o, main_pin_osc_select_o,
      sub_external_input_select_o, sub_ext_input_pin_select_o,
      sub_pin_output_enable_o}, 8'h1f);
    wr(ccs_pkg::PROC_CLK_CTRL_OFS, 8'h10);
    wait_stat(1'b0, 1'b1);
    wr(ccs_pkg::PROC_CLK_CTRL_OFS, 8'h03);
    wait_stat(1'b0, 1'b0);
    rd(ccs_pkg::PROC_CLK_CTRL_OFS, rv); chk(rv, 8'h03);
    count_ticks(8'h04);
  endtask

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    fih_tick_i = 1'b1;
    internal_fast_osc_running_i = 1'b1;
    sub_osc_stable_flag_i = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_divider();
    t_main_src();
    t_sub();
    t_rereset();
    report_and_stop();
  end
  // Whole run stays just under 1000 cycles, even with every status wait capped
  initial begin
    repeat (2000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end
endmodule
